// ==== rtl/cpwm_pkg.sv ====
// Behaviour
// - The count source is selectable among the system clock, its divide-by-2, 4, 8, 32 versions and the fast internal oscillator clock.
// - The count source may instead be the external count clock pin, with software choosing the counting edge.
// - The channel counter increments once per count source cycle and a period spans period value plus one cycles.
// - Each PWM output is active for period value minus its duty value count source cycles per period.
// - Each PWM output is inactive for its duty value plus one count source cycles per period.
// - Writing one to a channel's run bit starts that channel counting.
// - With stop select set, writing zero to the run bit stops the counter at once and the outputs hold their level.
// - With stop select clear, the counter stops at the next period compare match.
// - After a stop at period match the outputs keep the level set by that match.
package cpwm_pkg;

    localparam int CPWM_NCH_MAX = 4;
    localparam int CPWM_NDUTY_MAX = 3;
    localparam int CPWM_CW = 16;
    localparam int CPWM_AW = 8;

    // Register map, byte addresses
    localparam logic [7:0] CPWM_START_OFS = 8'h00;
    localparam logic [7:0] CPWM_STATUS_OFS = 8'h04;
    // Channel c sits in the 32-byte window starting at (c + 1) * 0x20
    localparam logic [4:0] CPWM_CH_CFG = 5'h00;
    localparam logic [4:0] CPWM_CH_PERIOD = 5'h04;
    localparam logic [4:0] CPWM_CH_COUNT = 5'h08;
    localparam logic [4:0] CPWM_CH_DUTY0 = 5'h0c;
    localparam logic [4:0] CPWM_CH_DUTY_STEP = 5'h04;

    // Field positions
    localparam int CPWM_RUN_LSB = 0;
    localparam int CPWM_STOPSEL_LSB = 8;
    localparam int CPWM_SRC_LSB = 0;
    localparam int CPWM_EDGE_LSB = 4;

    // Count source encodings
    localparam logic [2:0] CPWM_SRC_DIV1 = 3'h0;
    localparam logic [2:0] CPWM_SRC_DIV2 = 3'h1;
    localparam logic [2:0] CPWM_SRC_DIV4 = 3'h2;
    localparam logic [2:0] CPWM_SRC_DIV8 = 3'h3;
    localparam logic [2:0] CPWM_SRC_DIV32 = 3'h4;
    localparam logic [2:0] CPWM_SRC_FOSC = 3'h5;
    localparam logic [2:0] CPWM_SRC_EXT = 3'h6;
    localparam logic [1:0] CPWM_EDGE_RISE = 2'h0;
    localparam logic [1:0] CPWM_EDGE_FALL = 2'h1;
    localparam logic [1:0] CPWM_EDGE_BOTH = 2'h2;

    localparam logic [1:0] CPWM_RESP_OKAY = 2'h0;
    localparam logic [1:0] CPWM_RESP_SLVERR = 2'h2;
    localparam logic [CPWM_CW-1:0] CPWM_PERIOD_RST = 16'h0000;
    localparam logic [CPWM_CW-1:0] CPWM_DUTY_RST = 16'h0000;

    typedef struct packed {
        logic [1:0] edge_sel;
        logic [2:0] src;
    } cpwm_cfg_t;

    typedef struct packed {
        logic counting;
        logic [CPWM_CW-1:0] count;
        logic [CPWM_NDUTY_MAX-1:0] pwm;
    } cpwm_ch_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_have;
        logic w_have;
        logic [CPWM_AW-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [CPWM_NCH_MAX-1:0] run_req;
        logic [CPWM_NCH_MAX-1:0] stop_sel;
        cpwm_cfg_t [CPWM_NCH_MAX-1:0] cfg;
        logic [CPWM_NCH_MAX-1:0][CPWM_CW-1:0] period;
        logic [CPWM_NCH_MAX-1:0][CPWM_NDUTY_MAX-1:0][CPWM_CW-1:0] duty;
        logic [4:0] presc;
        logic [1:0] fosc_sync;
        logic [1:0] ext_sync;
        logic fosc_prev;
        logic ext_prev;
        logic [CPWM_NCH_MAX-1:0] tick;
    } cpwm_regs_t;

endpackage

// ==== rtl/cpwm_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpwm_channel #(
    parameter int NDUTY = 3
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic tick,
    input wire logic run_req,
    input wire logic stop_sel,
    input wire logic [cpwm_pkg::CPWM_CW-1:0] period,
    input wire logic [NDUTY-1:0][cpwm_pkg::CPWM_CW-1:0] duty,
    // State
    output var logic counting,
    output var logic [cpwm_pkg::CPWM_CW-1:0] count,
    output var logic [NDUTY-1:0] pwm
);
    import cpwm_pkg::*;

    if (NDUTY < 1 || NDUTY > CPWM_NDUTY_MAX) begin : g_bad_param
        $error("cpwm_channel: NDUTY out of range");
    end

    cpwm_ch_t q, d;

    always_comb begin
        d = q;
        if (!q.counting) begin
            if (run_req) begin
                d.counting = 1'b1;
            end
        end else if (!run_req && stop_sel) begin
            d.counting = 1'b0;
        end else if (tick) begin
            if (q.count == period) begin
                d.count = '0;
                d.pwm = '0;
                if (!run_req) begin
                    d.counting = 1'b0;
                end
            end else begin
                d.count = CPWM_CW'(q.count + 1'b1);
                for (int j = 0; j < NDUTY; j++) begin
                    if (q.count == duty[j]) begin
                        d.pwm[j] = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign counting = q.counting;
    assign count = q.count;
    assign pwm = q.pwm[NDUTY-1:0];
endmodule
`default_nettype wire

// ==== rtl/cpwm_top.sv ====
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cpwm_top #(
    parameter int NCH = 2,
    parameter int NDUTY = 3
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [cpwm_pkg::CPWM_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output var logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output var logic s_axi_wready,
    // AXI4-Lite write response
    output var logic [1:0] s_axi_bresp,
    output var logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [cpwm_pkg::CPWM_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output var logic s_axi_arready,
    output var logic [31:0] s_axi_rdata,
    output var logic [1:0] s_axi_rresp,
    output var logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Count clock pins, asynchronous
    input wire logic fast_internal_osc_clock,
    input wire logic ext_count_clock_pin,
    // PWM outputs, active high
    output var logic [NCH-1:0][NDUTY-1:0] pwm_out
);
    import cpwm_pkg::*;

    // Refused at elaboration: the register map has room for four channels of three outputs
    if (NCH < 1 || NCH > CPWM_NCH_MAX || NDUTY < 1 || NDUTY > CPWM_NDUTY_MAX) begin : g_bad_param
        $error("cpwm_top: NCH or NDUTY out of range");
    end

    cpwm_regs_t q, d;
    logic [CPWM_NCH_MAX-1:0] ch_counting;
    logic [CPWM_NCH_MAX-1:0][CPWM_CW-1:0] ch_count;
    logic [31:0] rd_data;
    logic rd_ok;

    for (genvar c = 0; c < CPWM_NCH_MAX; c++) begin : g_ch
        if (c < NCH) begin : g_on
            cpwm_channel #(.NDUTY(NDUTY)) u_ch (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(q.tick[c]),
                .run_req(q.run_req[c]),
                .stop_sel(q.stop_sel[c]),
                .period(q.period[c]),
                .duty(q.duty[c][NDUTY-1:0]),
                .counting(ch_counting[c]),
                .count(ch_count[c]),
                .pwm(pwm_out[c])
            );
        end else begin : g_off
            assign ch_counting[c] = 1'b0;
            assign ch_count[c] = '0;
        end
    end

    // Read mux, registered into rdata on acceptance
    always_comb begin
        logic [2:0] sec;
        logic [4:0] off;
        sec = s_axi_araddr[7:5];
        off = s_axi_araddr[4:0];
        rd_data = '0;
        rd_ok = 1'b0;
        if (s_axi_araddr == CPWM_START_OFS) begin
            rd_ok = 1'b1;
            rd_data[CPWM_RUN_LSB +: CPWM_NCH_MAX] = q.run_req;
            rd_data[CPWM_STOPSEL_LSB +: CPWM_NCH_MAX] = q.stop_sel;
        end else if (s_axi_araddr == CPWM_STATUS_OFS) begin
            rd_ok = 1'b1;
            rd_data[CPWM_NCH_MAX-1:0] = ch_counting;
        end
        for (int c = 0; c < NCH; c++) begin
            if (sec == 3'(c + 1)) begin
                if (off == CPWM_CH_CFG) begin
                    rd_ok = 1'b1;
                    rd_data[CPWM_SRC_LSB +: 3] = q.cfg[c].src;
                    rd_data[CPWM_EDGE_LSB +: 2] = q.cfg[c].edge_sel;
                end else if (off == CPWM_CH_PERIOD) begin
                    rd_ok = 1'b1;
                    rd_data[CPWM_CW-1:0] = q.period[c];
                end else if (off == CPWM_CH_COUNT) begin
                    rd_ok = 1'b1;
                    rd_data[CPWM_CW-1:0] = ch_count[c];
                end
                for (int j = 0; j < NDUTY; j++) begin
                    if (off == 5'(CPWM_CH_DUTY0 + CPWM_CH_DUTY_STEP * j)) begin
                        rd_ok = 1'b1;
                        rd_data[CPWM_CW-1:0] = q.duty[c][j];
                    end
                end
            end
        end
    end

    always_comb begin
        logic [31:0] m;
        logic [2:0] sec;
        logic [4:0] off;
        logic hit;
        logic fo_edge;
        logic ex_rise;
        logic ex_fall;
        logic ex_edge;
        d = q;
        m = '0;
        hit = 1'b0;
        sec = q.awaddr[7:5];
        off = q.awaddr[4:0];
        fo_edge = 1'b0;
        ex_rise = 1'b0;
        ex_fall = 1'b0;
        ex_edge = 1'b0;
        for (int b = 0; b < 4; b++) begin
            m[8*b +: 8] = q.wstrb[b] ? 8'hff : 8'h00;
        end

        // Count sources; first sync stage feeds only the second
        d.presc = 5'(q.presc + 1'b1);
        d.fosc_sync = {q.fosc_sync[0], fast_internal_osc_clock};
        d.ext_sync = {q.ext_sync[0], ext_count_clock_pin};
        d.fosc_prev = q.fosc_sync[1];
        d.ext_prev = q.ext_sync[1];
        fo_edge = q.fosc_sync[1] && !q.fosc_prev;
        ex_rise = q.ext_sync[1] && !q.ext_prev;
        ex_fall = !q.ext_sync[1] && q.ext_prev;
        for (int c = 0; c < CPWM_NCH_MAX; c++) begin
            case (q.cfg[c].edge_sel)
                CPWM_EDGE_RISE: ex_edge = ex_rise;
                CPWM_EDGE_FALL: ex_edge = ex_fall;
                CPWM_EDGE_BOTH: ex_edge = ex_rise || ex_fall;
                default: ex_edge = ex_rise;
            endcase
            case (q.cfg[c].src)
                CPWM_SRC_DIV1: d.tick[c] = 1'b1;
                CPWM_SRC_DIV2: d.tick[c] = &q.presc[0:0];
                CPWM_SRC_DIV4: d.tick[c] = &q.presc[1:0];
                CPWM_SRC_DIV8: d.tick[c] = &q.presc[2:0];
                CPWM_SRC_DIV32: d.tick[c] = &q.presc[4:0];
                CPWM_SRC_FOSC: d.tick[c] = fo_edge;
                CPWM_SRC_EXT: d.tick[c] = ex_edge;
                default: d.tick[c] = 1'b0;
            endcase
        end

        // Write channel
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (s_axi_awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.aw_have && q.w_have && !q.bvalid) begin
            if (q.awaddr == CPWM_START_OFS) begin
                hit = 1'b1;
                for (int c = 0; c < NCH; c++) begin
                    if (m[CPWM_RUN_LSB + c]) begin
                        d.run_req[c] = q.wdata[CPWM_RUN_LSB + c];
                    end
                    if (m[CPWM_STOPSEL_LSB + c]) begin
                        d.stop_sel[c] = q.wdata[CPWM_STOPSEL_LSB + c];
                    end
                end
            end else if (q.awaddr == CPWM_STATUS_OFS) begin
                hit = 1'b1;
            end
            for (int c = 0; c < NCH; c++) begin
                if (sec == 3'(c + 1)) begin
                    if (off == CPWM_CH_CFG) begin
                        hit = 1'b1;
                        if (q.wstrb[0]) begin
                            d.cfg[c].src = q.wdata[CPWM_SRC_LSB +: 3];
                            d.cfg[c].edge_sel = q.wdata[CPWM_EDGE_LSB +: 2];
                        end
                    end else if (off == CPWM_CH_PERIOD) begin
                        hit = 1'b1;
                        d.period[c] = (q.period[c] & ~m[15:0]) | (q.wdata[15:0] & m[15:0]);
                    end else if (off == CPWM_CH_COUNT) begin
                        hit = 1'b1;
                    end
                    for (int j = 0; j < NDUTY; j++) begin
                        if (off == 5'(CPWM_CH_DUTY0 + CPWM_CH_DUTY_STEP * j)) begin
                            hit = 1'b1;
                            d.duty[c][j] = (q.duty[c][j] & ~m[15:0]) | (q.wdata[15:0] & m[15:0]);
                        end
                    end
                end
            end
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = hit ? CPWM_RESP_OKAY : CPWM_RESP_SLVERR;
        end
        // Ready only when the holding slot is empty; no skid buffer needed
        d.awready = !d.aw_have && !d.bvalid;
        d.wready = !d.w_have && !d.bvalid;

        // Read channel
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rdata = rd_data;
            d.rresp = rd_ok ? CPWM_RESP_OKAY : CPWM_RESP_SLVERR;
        end
        d.arready = !d.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.period <= '{default: CPWM_PERIOD_RST};
            q.duty <= '{default: '{default: CPWM_DUTY_RST}};
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
endmodule
`default_nettype wire

// ==== verification/cpwm_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpwm_checker #(
    parameter int NCH = 2,
    parameter int NDUTY = 3
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Outputs
    input wire logic [NCH-1:0][NDUTY-1:0] pwm_out
);
    import cpwm_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during response");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == CPWM_RESP_SLVERR |-> s_axi_rdata == 0)
        else $error("error read carries data");
    // Whenever channel 0 output 0 falls, all channel 0 outputs are low, as at period start
    AST_PWM_FALL: assert property ($fell(pwm_out[0][0]) |-> pwm_out[0] == '0)
        else $error("output fell alone");
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cpwm_pkg::*;
    localparam int NCH = 2;
    localparam int NDUTY = 3;
    logic aclk, aresetn;
    logic slow_clk = 1'h0;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, c1;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [NCH-1:0][NDUTY-1:0] pwm_out;
    logic [NDUTY-1:0] p;
    int err_count = 0;
    int n_tests = 0;
    int sc = 0;
    int m, n, h, l, i;
    // Ticks per count: div1..div32, fast osc, ext rise, ext fall, ext both
    int dv[9] = '{1, 2, 4, 8, 32, 6, 6, 6, 3};
    logic [5:0] cf[9] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h16, 6'h26};

    cpwm_top #(.NCH(NCH), .NDUTY(NDUTY)) u_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fast_internal_osc_clock(slow_clk),
        .ext_count_clock_pin(slow_clk), .pwm_out
    );

    initial begin
        aclk = 1'h0;
        forever #25 aclk = ~aclk;
    end

    // Edge-locked slow clock, period 6 cycles, keeps expected widths exact
    always @(posedge aclk) begin
        sc <= (sc + 1) % 3;
        if (sc == 2) slow_clk <= ~slow_clk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        // Waits for the answer; only the watchdog ends a hang
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        // Ready stays high, so back-to-back calls never drive it twice in one step
        resp = s_axi_bresp;
    endtask

    task automatic rdr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
    endtask

    // Widths of one active and the following inactive run of one output
    task automatic meas(input int c, input int j);
        int k;
        k = 0;
        h = 0;
        l = 0;
        while (pwm_out[c][j] !== 1'h0 && k < 3000) begin
            @(posedge aclk);
            k++;
        end
        while (pwm_out[c][j] !== 1'h1 && k < 3000) begin
            @(posedge aclk);
            k++;
        end
        while (pwm_out[c][j] === 1'h1 && h < 3000) begin
            @(posedge aclk);
            h++;
        end
        while (pwm_out[c][j] === 1'h0 && l < 3000) begin
            @(posedge aclk);
            l++;
        end
    endtask

    task automatic wrap_up();
        $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        err_count++;
        wrap_up();
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        aresetn = 1'h0;
        void'($urandom(32'hff8bed0e));
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rdr(8'h24);
        chk(rd, 32'h0);
        rdr(8'h00);
        chk(rd, 32'h0);
        rdr(8'hfc);
        chk({rd[29:0], resp}, {30'h0, CPWM_RESP_SLVERR});
        wr(8'hfc, 32'hffffffff);
        chk(resp, CPWM_RESP_SLVERR);
        for (i = 0; i < 9; i++) begin
            m = 2 + $urandom % 6;
            n = $urandom % m;
            wr(8'h20, {26'h0, cf[i]});
            wr(8'h24, 32'(m));
            wr(8'h2c, 32'(n));
            wr(8'h00, 32'h1);
            rdr(8'h04);
            chk(rd, 32'h1);
            meas(0, 0);
            chk(h, (m - n) * dv[i]);
            chk(l, (n + 1) * dv[i]);
            // Stop at period match, so a smaller next period starts from zero
            wr(8'h00, 32'h0);
            do begin
                rdr(8'h04);
            end while (rd[0] !== 1'h0);
            rdr(8'h08);
            chk(rd, 32'h0);
            chk(pwm_out[0], 3'h0);
        end
        // Immediate stop while output 0 is active, level kept
        wr(8'h20, 32'h4);
        wr(8'h00, 32'h1);
        while (pwm_out[0][0] !== 1'h1) @(posedge aclk);
        wr(8'h00, 32'h100);
        p = pwm_out[0];
        rdr(8'h08);
        c1 = rd;
        repeat (20) @(posedge aclk);
        rdr(8'h08);
        chk(rd, c1);
        chk(pwm_out[0], p);
        chk(pwm_out[0][0], 1'h1);
        wr(8'h00, 32'h1);
        repeat (10) @(posedge aclk);
        wr(8'h00, 32'h0);
        repeat (300) @(posedge aclk);
        rdr(8'h08);
        chk(rd, 32'h0);
        rdr(8'h04);
        chk(rd, 32'h0);
        chk(pwm_out[0], 3'h0);
        // Second channel, duty output 1, undivided system clock
        m = 2 + $urandom % 6;
        n = $urandom % m;
        wr(8'h44, 32'(m));
        wr(8'h50, 32'(n));
        wr(8'h00, 32'h2);
        meas(1, 1);
        chk(h, m - n);
        chk(l, n + 1);
        wrap_up();
    end
endmodule

bind cpwm_top cpwm_checker #(.NCH(NCH), .NDUTY(NDUTY)) u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_out
);
`default_nettype wire
